/* File: logic/mlf_top.sv */
/*
 Link supervision, indicators and fail-safe outputs of an expansion module,
 with an APB register file. Assumes pins are asynchronous to pclk and an
 APB master keeps the request stable until pready.
*/
// Our own choices: the APB interface to the registers and the register addresses.
// Contract
// - Run indicator green linked, red unlinked, orange init
// - Field-bus indicator green, red, flashing at zero
// - Field-bus supply loss cuts links to right
// - Switching outputs reset 40 to 100 ms
// - Bus indicator green, red, orange when programming
// - Base power or link loss zeroes outputs
// - Run indicator red one second after loss
// - Base power return sends recovery states
// - Bus fault: configured reaction, red after 5s
// - Expansion I/O presented in installation order
// - Voltage present reads one, absent zero
// - Constant connectors read one and zero
// - Unused inputs default to a safe level
// - Dual-use inputs digital or analog by selection
// - Middle four inputs usable as fast inputs
// - 32 shift bits and 64 blank outputs
`timescale 1ns/1ps
`include "mlf_cfg.svh"

module mlf_top
    import mlf_pkg::*;
#(
    parameter int unsigned OUT_RST_CYC = `MLF_OUT_RST_MS * `MLF_CLK_KHZ,
    parameter int unsigned RED_CYC     = `MLF_RED_MS * `MLF_CLK_KHZ,
    parameter int unsigned BUS_RED_CYC = `MLF_BUS_RED_MS * `MLF_CLK_KHZ,
    parameter int unsigned FLASH_CYC   = `MLF_FLASH_MS * `MLF_CLK_KHZ
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Status pins
    input  wire mlf_pins_t   pins,
    // Outputs and indicators
    output logic [15:0]      sw_out,
    output mlf_led_t         run_led,
    output mlf_led_t         field_bus_indicator,
    output mlf_led_t         bus_led,
    output logic             right_link_en,
    output logic             recov_valid,
    output logic [15:0]      recov_data,
    output logic [3:0]       analog_route
);

    // Dual-use input positions; the fast inputs are fixed at 2 to 5
    localparam int DUAL_A = 0;
    localparam int DUAL_B = 1;
    localparam int DUAL_C = 6;
    localparam int DUAL_D = 7;

    mlf_state_t st;
    mlf_state_t next_st;

    // Known register offset
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `MLF_OFS_OUT)   || (a == `MLF_OFS_RECOV) ||
                    (a == `MLF_OFS_CFG)   || (a == `MLF_OFS_STAT)  ||
                    (a == `MLF_OFS_DIN)   || (a == `MLF_OFS_SHIFT) ||
                    (a == `MLF_OFS_SHIN)  || (a == `MLF_OFS_BLK_LO) ||
                    (a == `MLF_OFS_BLK_HI);
    endfunction : is_mapped

    // Saturating timer step
    function automatic logic [31:0] sat_inc(input logic [31:0] c);
        sat_inc = (c == 32'hFFFFFFFF) ? c : c + 32'h00000001;
    endfunction : sat_inc

    // Digital input word as software sees it
    function automatic logic [31:0] din_word(input mlf_state_t s);
        logic [7:0] d;
        d = s.din_filt & s.cfg[`MLF_CFG_USE +: 8];
        d[DUAL_A] = d[DUAL_A] & ~s.cfg[`MLF_CFG_AN + 0];
        d[DUAL_B] = d[DUAL_B] & ~s.cfg[`MLF_CFG_AN + 1];
        d[DUAL_C] = d[DUAL_C] & ~s.cfg[`MLF_CFG_AN + 2];
        d[DUAL_D] = d[DUAL_D] & ~s.cfg[`MLF_CFG_AN + 3];
        din_word = 32'h00000000;
        din_word[7:0] = d;
        din_word[`MLF_DIN_HI] = 1'b1;
        din_word[`MLF_DIN_LO] = 1'b0;
        din_word[`MLF_DIN_EXP +: 16] = s.sync.exp_in;
    endfunction : din_word

    logic        lost;
    logic        base_rise;
    logic        bus_bad;
    logic        acc;
    logic [31:0] rd;

    // Next-state logic for the whole block
    always_comb
    begin
        next_st = st;
        // Two-stage synchroniser; only the second stage is read
        next_st.meta = pins;
        next_st.sync = st.meta;

        // Slow inputs need two equal samples, middle four go straight
        next_st.din_prev = st.sync.din;
        for (int i = 0; i < 8; i++)
        begin
            if (i >= 2 && i <= 5)
                next_st.din_filt[i] = st.sync.din[i];
            else if (st.sync.din[i] == st.din_prev[i])
                next_st.din_filt[i] = st.din_prev[i];
        end

        // Loss of the left link or field-bus supply
        lost = !st.sync.left_link_ok || !st.sync.fb_supply_ok;
        next_st.loss_cnt = lost ? sat_inc(st.loss_cnt) : 32'h00000000;
        bus_bad = !st.sync.bb_bus_ok;
        next_st.bus_cnt = bus_bad ? sat_inc(st.bus_cnt) : 32'h00000000;
        base_rise = st.sync.base_power_ok && !st.base_prev;
        next_st.base_prev = st.sync.base_power_ok;

        // Right-hand modules lose the link with field-bus supply
        next_st.right_en = st.sync.fb_supply_ok && st.sync.left_link_ok;

        // Run/stop indicator; red only after the one-second grace
        if (st.sync.init_active)
            next_st.run_led = MLF_ORANGE;
        else if (lost && st.loss_cnt >= RED_CYC)
            next_st.run_led = MLF_RED;
        else if (!lost)
            next_st.run_led = MLF_GREEN;

        // Flash timebase, one toggle per half period
        if (st.flash_cnt >= FLASH_CYC - 1)
        begin
            next_st.flash_cnt = 32'h00000000;
            next_st.flash = !st.flash;
        end
        else
            next_st.flash_cnt = st.flash_cnt + 32'h00000001;

        // Field-bus indicator; address zero outranks link state
        if (st.cfg[`MLF_CFG_ADDR +: 5] == 5'h00)
            next_st.fb_led = st.flash ? MLF_YELLOW : MLF_RED;
        else if (st.sync.fb_comm_ok)
            next_st.fb_led = MLF_GREEN;
        else
            next_st.fb_led = MLF_RED;

        // Building-bus indicator; red waits out short glitches
        if (bus_bad && st.bus_cnt >= BUS_RED_CYC)
            next_st.bus_led = MLF_RED;
        else if (!bus_bad && st.sync.bb_prog_mode)
            next_st.bus_led = MLF_ORANGE;
        else if (!bus_bad)
            next_st.bus_led = MLF_GREEN;

        // Recovery states go out once as base power returns
        next_st.tx_valid = base_rise;
        if (base_rise)
            next_st.tx_data = st.recov;

        // APB access phase; one wait state, then pready
        acc = psel && penable && st.pready;
        next_st.pready = psel && penable && !st.pready;
        next_st.pslverr = psel && penable && !st.pready && !is_mapped(paddr);
        if (acc && pwrite)
        begin
            unique case (paddr)
                `MLF_OFS_OUT:    next_st.out_req = pwdata[15:0];
                `MLF_OFS_RECOV:  next_st.recov = pwdata[15:0];
                `MLF_OFS_CFG:    next_st.cfg = pwdata;
                `MLF_OFS_SHIFT:  next_st.shift = pwdata;
                `MLF_OFS_SHIN:   next_st.shift = {st.shift[30:0], pwdata[0]};
                `MLF_OFS_BLK_LO: next_st.blank[31:0] = pwdata;
                `MLF_OFS_BLK_HI: next_st.blank[63:32] = pwdata;
                default:         next_st.out_req = st.out_req;
            endcase
        end
        next_st.an_route = st.cfg[`MLF_CFG_AN +: 4];

        // Read mux, loaded with the answer
        unique case (paddr)
            `MLF_OFS_OUT:    rd = {16'h0000, st.out_req};
            `MLF_OFS_RECOV:  rd = {16'h0000, st.recov};
            `MLF_OFS_CFG:    rd = st.cfg;
            `MLF_OFS_STAT:   rd = {16'h0000, st.sw_out[0], st.right_en,
                                   st.sync.base_power_ok, st.sync.bb_bus_ok,
                                   st.sync.fb_supply_ok, st.sync.left_link_ok,
                                   1'b0, st.bus_led, st.fb_led, st.run_led};
            `MLF_OFS_DIN:    rd = din_word(st);
            `MLF_OFS_SHIFT:  rd = st.shift;
            `MLF_OFS_BLK_LO: rd = st.blank[31:0];
            `MLF_OFS_BLK_HI: rd = st.blank[63:32];
            default:         rd = 32'h00000000;
        endcase
        if (psel && penable && !st.pready && !pwrite)
            next_st.prdata = rd;

        // Fail-safe output priority: power, recovery, link, bus
        if (!st.sync.base_power_ok)
            next_st.sw_out = `MLF_OUT_RST;
        else if (base_rise)
            next_st.sw_out = st.recov;
        else if (lost && st.loss_cnt >= OUT_RST_CYC)
            next_st.sw_out = `MLF_OUT_RST;
        else if (bus_bad && !st.cfg[`MLF_CFG_HOLD])
            next_st.sw_out = `MLF_OUT_RST;
        else if (!(bus_bad && st.cfg[`MLF_CFG_HOLD]))
            next_st.sw_out = st.out_req;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.cfg <= `MLF_CFG_RST;
        end
        else
            st <= next_st;
    end

    // Outputs straight from the state flops
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign prdata = st.prdata;
    assign sw_out = st.sw_out;
    assign run_led = st.run_led;
    assign field_bus_indicator = st.fb_led;
    assign bus_led = st.bus_led;
    assign right_link_en = st.right_en;
    assign recov_valid = st.tx_valid;
    assign recov_data = st.tx_data;
    assign analog_route = st.an_route;

    // Checks on the indicators, fail-safe paths and inputs
    a_init_orange: assert property (@(posedge pclk) disable iff (!presetn)
        st.sync.init_active |=> run_led == MLF_ORANGE)
        else $error("init phase without orange run indicator");

    a_zero_flash: assert property (@(posedge pclk) disable iff (!presetn)
        st.cfg[`MLF_CFG_ADDR +: 5] == 5'h00 |=>
        field_bus_indicator == MLF_RED || field_bus_indicator == MLF_YELLOW)
        else $error("address zero not flashing red/yellow");

    a_right_cut: assert property (@(posedge pclk) disable iff (!presetn)
        !st.sync.fb_supply_ok |=> !right_link_en)
        else $error("right link kept without field-bus supply");

    a_out_kill: assert property (@(posedge pclk) disable iff (!presetn)
        (lost && st.loss_cnt >= OUT_RST_CYC && st.sync.base_power_ok && !base_rise)
        |=> sw_out == 16'h0000)
        else $error("outputs not reset after link loss");

    a_prog_orange: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sync.bb_bus_ok && st.sync.bb_prog_mode) |=> bus_led == MLF_ORANGE)
        else $error("programming mode not orange");

    a_power_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !st.sync.base_power_ok [*2] |=> sw_out == 16'h0000)
        else $error("outputs live without base power");

    a_red_delay: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(run_led == MLF_RED) |-> $past(st.loss_cnt) >= RED_CYC)
        else $error("run indicator red too early");

    a_recov_send: assert property (@(posedge pclk) disable iff (!presetn)
        base_rise |=> recov_valid && recov_data == $past(st.recov)
        ##1 !recov_valid)
        else $error("recovery states not sent once");

    a_bus_red: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(bus_led == MLF_RED) |-> $past(st.bus_cnt) >= BUS_RED_CYC)
        else $error("bus red before five seconds");

    a_const_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && !pready && paddr == `MLF_OFS_DIN)
        |=> prdata[`MLF_DIN_HI +: 2] == 2'b01)
        else $error("constant connectors misread");

    a_run_green: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.sync.init_active && !lost) |=> run_led == MLF_GREEN)
        else $error("linked module not showing green");

    a_fast_pass: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> st.din_filt[5:2] == $past(st.sync.din[5:2]))
        else $error("fast inputs delayed by the filter");

    a_bus_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.sync.bb_bus_ok && !st.cfg[`MLF_CFG_HOLD] && !base_rise)
        |=> sw_out == 16'h0000)
        else $error("outputs live on bus fault without hold");

endmodule : mlf_top

/* File: logic/mlf_cfg.svh */
/*
 Offsets, field positions, reset values and times for the link fail-safe block.
 Assumes a 25 MHz APB clock; times are in milliseconds.
*/
`ifndef MLF_CFG_SVH
`define MLF_CFG_SVH

// Clock rate and documented times
`define MLF_CLK_KHZ     25000
`define MLF_OUT_RST_MS  40
`define MLF_RED_MS      1000
`define MLF_BUS_RED_MS  5000
`define MLF_FLASH_MS    250

// Register byte offsets
`define MLF_OFS_OUT     8'h00
`define MLF_OFS_RECOV   8'h04
`define MLF_OFS_CFG     8'h08
`define MLF_OFS_STAT    8'h0C
`define MLF_OFS_DIN     8'h10
`define MLF_OFS_SHIFT   8'h14
`define MLF_OFS_SHIN    8'h18
`define MLF_OFS_BLK_LO  8'h1C
`define MLF_OFS_BLK_HI  8'h20

// Field positions
`define MLF_CFG_HOLD    0
`define MLF_CFG_ADDR    8
`define MLF_CFG_AN      16
`define MLF_CFG_USE     24
`define MLF_DIN_HI      8
`define MLF_DIN_LO      9
`define MLF_DIN_EXP     16

// Reset values
`define MLF_CFG_RST     32'hFF000100
`define MLF_OUT_RST     16'h0000

`endif

/* File: logic/mlf_pkg.sv */
/*
 Types of the link fail-safe block: indicator codes, pin group and state.
 Assumes mlf_cfg.svh is included by the design file.
*/
package mlf_pkg;

    // Indicator colour codes, one per state
    typedef enum logic [2:0] {
        MLF_OFF,
        MLF_GREEN,
        MLF_RED,
        MLF_ORANGE,
        MLF_YELLOW
    } mlf_led_t;

    // Status pins from the module chain and buses
    typedef struct packed {
        logic        left_link_ok;
        logic        init_active;
        logic        fb_comm_ok;
        logic        fb_supply_ok;
        logic        bb_bus_ok;
        logic        bb_prog_mode;
        logic        base_power_ok;
        logic [7:0]  din;
        logic [15:0] exp_in;
    } mlf_pins_t;

    // Whole state of the block
    typedef struct packed {
        mlf_pins_t   meta;
        mlf_pins_t   sync;
        logic [7:0]  din_prev;
        logic [7:0]  din_filt;
        logic        base_prev;
        logic [15:0] out_req;
        logic [15:0] recov;
        logic [31:0] cfg;
        logic [31:0] shift;
        logic [63:0] blank;
        logic [31:0] loss_cnt;
        logic [31:0] bus_cnt;
        logic [31:0] flash_cnt;
        logic        flash;
        logic [15:0] sw_out;
        mlf_led_t    run_led;
        mlf_led_t    fb_led;
        mlf_led_t    bus_led;
        logic        right_en;
        logic        tx_valid;
        logic [15:0] tx_data;
        logic [3:0]  an_route;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } mlf_state_t;

endpackage : mlf_pkg

/* File: tb/mlf_far_model.sv */
/*
 Far side of the link fail-safe block: base unit, left neighbour and buses.
 Assumes the bench sets the wanted pin states just after a rising edge.
*/
`timescale 1ns/1ps

module mlf_far_model
    import mlf_pkg::*;
(
    // Clock and reset
    input  wire logic      pclk,
    input  wire logic      presetn,
    // Wanted pin states from the bench
    input  wire mlf_pins_t want,
    // Pins toward the block
    output mlf_pins_t      pins
);

    logic                  mod_up;

    // Pins follow the bench one cycle later, all low in reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins <= '0;
            mod_up <= 1'b0;
        end
        else
        begin
            pins <= want;
            // Module supply counts as up once its link is first seen
            mod_up <= mod_up | want.left_link_ok;
            // Base supply only after the module side is up; a later link loss
            // must not take base power with it
            pins.base_power_ok <= want.base_power_ok & mod_up;
            // Bus inputs read zero while the bus module is down
            if (!want.bb_bus_ok)
                pins.exp_in <= '0;
        end
    end

endmodule : mlf_far_model

/* File: tb/tb_mlf_top.sv */
/*
 Self-checking bench of mlf_top: a table of pin states, then timed cases.
 Assumes mlf_far_model on the pins and shortened time parameters.
*/
`timescale 1ns/1ps
`include "mlf_cfg.svh"

module tb_mlf_top
    import mlf_pkg::*;
;
    // Pin table row: left, init, fb comm, fb supply, prog
    typedef struct packed {
        logic [4:0] pin;
        mlf_led_t   run;
        mlf_led_t   fb;
        mlf_led_t   bus;
    } mlf_row_t;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] sw_out, recov_data;
    logic        right_link_en, recov_valid;
    logic [3:0]  analog_route;
    mlf_led_t    run_led, fbi, bus_led, v;
    mlf_pins_t   want, pins;
    mlf_row_t    rows [4];
    int          fail_count, cmp_count, n;

    mlf_far_model far (.pclk(pclk), .presetn(presetn), .want(want), .pins(pins));

    // Short times keep the run brief
    mlf_top #(.OUT_RST_CYC(20), .RED_CYC(50), .BUS_RED_CYC(100), .FLASH_CYC(8)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .pins(pins), .sw_out(sw_out),
        .run_led(run_led), .field_bus_indicator(fbi), .bus_led(bus_led),
        .right_link_en(right_link_en), .recov_valid(recov_valid),
        .recov_data(recov_data), .analog_route(analog_route));

    // 25 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask : wt

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait on a slave that never answers
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask : apb

    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Watchdog, well beyond the planned run
    initial
    begin
        #200us;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        fail_count = 0;
        cmp_count = 0;
        want = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 16'h0000};
        rows[0] = '{5'b10110, MLF_GREEN, MLF_GREEN, MLF_GREEN};
        rows[1] = '{5'b11111, MLF_ORANGE, MLF_GREEN, MLF_ORANGE};
        rows[2] = '{5'b10010, MLF_GREEN, MLF_RED, MLF_GREEN};
        rows[3] = '{5'b11011, MLF_ORANGE, MLF_RED, MLF_ORANGE};
        wt(4);
        presetn <= 1'b1;
        wt(8);
        // Reset value and a refused address
        apb(1'b0, `MLF_OFS_CFG, 32'h0);
        chk(rd, `MLF_CFG_RST);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, `MLF_OFS_DIN, 32'h0);
        chk(32'(rd[9:8]), 32'h1);
        // Ordinary pin states from the table
        foreach (rows[i])
        begin
            {want.left_link_ok, want.init_active, want.fb_comm_ok, want.fb_supply_ok,
             want.bb_prog_mode} <= rows[i].pin;
            wt(6);
            chk(32'(run_led), 32'(rows[i].run));
            chk(32'(fbi), 32'(rows[i].fb));
            chk(32'(bus_led), 32'(rows[i].bus));
            chk(32'(right_link_en), 32'h1);
        end
        want.fb_comm_ok <= 1'b1;
        want.init_active <= 1'b0;
        want.bb_prog_mode <= 1'b0;
        // Slave address zero flashes two colours
        apb(1'b1, `MLF_OFS_CFG, 32'hFF000000);
        wt(5);
        v = fbi;
        chk(32'(v == MLF_RED || v == MLF_YELLOW), 32'h1);
        wt(8);
        chk(32'(fbi), 32'(v == MLF_RED ? MLF_YELLOW : MLF_RED));
        // Input order and constant connectors
        apb(1'b1, `MLF_OFS_CFG, 32'hFF000100);
        want.din <= 8'hFF;
        want.exp_in <= 16'h1234;
        wt(6);
        apb(1'b0, `MLF_OFS_DIN, 32'h0);
        chk(rd, 32'h123401FF);
        // Fast inputs arrive a cycle before the filtered slow ones; then use mask and analog routing
        want.din <= 8'h00;
        wt(3);
        apb(1'b0, `MLF_OFS_DIN, 32'h0);
        chk(32'(rd[7:0]), 32'hC3);
        want.din <= 8'hFF;
        apb(1'b1, `MLF_OFS_CFG, 32'h0F0F0100);
        wt(3);
        apb(1'b0, `MLF_OFS_DIN, 32'h0);
        chk(32'(rd[7:0]), 32'h0C);
        chk(32'(analog_route), 32'hF);
        apb(1'b1, `MLF_OFS_CFG, 32'hFF000100);
        // Link loss: outputs off after the count, red after the longer one
        apb(1'b1, `MLF_OFS_OUT, 32'h0000A5C3);
        wt(4);
        chk(32'(sw_out), 32'h0000A5C3);
        want.left_link_ok <= 1'b0;
        wt(12);
        chk(32'(sw_out), 32'h0000A5C3);
        chk(32'(right_link_en), 32'h0);
        wt(18);
        chk(32'(sw_out), 32'h0);
        wt(15);
        chk(32'(run_led == MLF_RED), 32'h0);
        wt(15);
        chk(32'(run_led), 32'(MLF_RED));
        want.left_link_ok <= 1'b1;
        wt(6);
        chk(32'(run_led), 32'(MLF_GREEN));
        // Base power loss and return
        apb(1'b1, `MLF_OFS_RECOV, 32'h00005A5A);
        apb(1'b1, `MLF_OFS_OUT, 32'h0000C33C);
        wt(4);
        want.base_power_ok <= 1'b0;
        wt(6);
        chk(32'(sw_out), 32'h0);
        want.base_power_ok <= 1'b1;
        n = 0;
        while (recov_valid !== 1'b1 && n < 20)
        begin
            wt(1);
            n++;
        end
        chk({recov_data, sw_out}, 32'h5A5A5A5A);
        // Bus fault: held outputs, then zeroed, red after the long wait
        apb(1'b1, `MLF_OFS_OUT, 32'h00000F0F);
        apb(1'b1, `MLF_OFS_CFG, 32'hFF000101);
        wt(4);
        want.bb_bus_ok <= 1'b0;
        wt(10);
        apb(1'b1, `MLF_OFS_OUT, 32'h0000F0F0);
        wt(4);
        chk(32'(sw_out), 32'h00000F0F);
        apb(1'b1, `MLF_OFS_CFG, 32'hFF000100);
        wt(4);
        chk(32'(sw_out), 32'h0);
        wt(60);
        chk(32'(bus_led == MLF_RED), 32'h0);
        wt(30);
        chk(32'(bus_led), 32'(MLF_RED));
        want.bb_bus_ok <= 1'b1;
        // Shift bits and blank outputs
        apb(1'b1, `MLF_OFS_SHIFT, 32'h80000001);
        apb(1'b1, `MLF_OFS_SHIN, 32'h1);
        apb(1'b0, `MLF_OFS_SHIFT, 32'h0);
        chk(rd, 32'h00000003);
        apb(1'b1, `MLF_OFS_BLK_HI, 32'hC0DE1234);
        apb(1'b0, `MLF_OFS_BLK_HI, 32'h0);
        chk(rd, 32'hC0DE1234);
        // Mid-run reset: outputs drop, configuration returns to its reset value
        apb(1'b1, `MLF_OFS_CFG, 32'h0F0F0101);
        presetn <= 1'b0;
        wt(2);
        chk(32'(sw_out), 32'h0);
        chk(32'(run_led), 32'(MLF_OFF));
        chk(32'(right_link_en), 32'h0);
        presetn <= 1'b1;
        wt(8);
        apb(1'b0, `MLF_OFS_CFG, 32'h0);
        chk(rd, `MLF_CFG_RST);
        wrap_up();
    end

endmodule : tb_mlf_top
